// ### core/cmpc_top.v
// Purpose: control and status logic around one analog comparator
// Assumes: presetn is power-on reset; warm_reset is a pclk pulse
// Notes:   APB slave, zero wait states, word-aligned registers
//
// Register access over APB was decided locally.
`include "cmpc_defines.vh"
`default_nettype none
module cmpc_top #(
    parameter MODE_DELAY_CYC = `CMPC_MODE_DELAY_CYC
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        comparator_raw,
    input  wire        sleep_active,
    input  wire        warm_reset,
    input  wire        pin_change_wake_flag,
    input  wire        instr_cycle,
    input  wire        port_pin_zero_i,
    input  wire        port_pin_one_i,
    input  wire        port_pin_two_i,
    output wire        port_pin_zero_o,
    output wire        port_pin_zero_oe,
    output wire        port_pin_one_o,
    output wire        port_pin_one_oe,
    output wire        port_pin_two_o,
    output wire        port_pin_two_oe,
    output wire        comparator_power,
    output wire        negative_input_select,
    output wire        positive_input_select,
    output wire        compare_result,
    output wire        result_unreliable,
    output wire        timer_tick_source,
    output wire        compare_wake_flag,
    output reg         compare_wake_reset
);

    ////////////////////////////////////////////////////////////////////
    // synchronised inputs: comparator output and the three pins

    wire [3:0] sync_v;

    cmpc_sync #(
        .W        (4)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({port_pin_two_i, port_pin_one_i,
                    port_pin_zero_i, comparator_raw}),
        .sync_out (sync_v)
    );

    wire raw_s  = sync_v[0];
    wire pin0_s = sync_v[1];
    wire pin1_s = sync_v[2];
    wire pin2_s = sync_v[3];

    ////////////////////////////////////////////////////////////////////
    // register state

    reg  [7:0] control_q;
    reg  [7:0] control_d;
    reg  [3:0] pin_dir_q;
    reg  [3:0] pin_dir_d;
    reg  [3:0] port_data_q;
    reg  [3:0] port_data_d;
    reg  [7:0] timer_opt_q;
    reg  [7:0] timer_opt_d;
    reg        wake_flag_q;
    reg        wake_flag_d;
    reg        ref_result_q;
    reg        ref_result_d;
    reg        armed_q;
    reg        armed_d;
    reg        released_q;

    ////////////////////////////////////////////////////////////////////
    // apb decode

    wire       access   = psel & penable;
    wire [5:0] idx      = paddr[7:2];
    wire       aligned  = (paddr[1:0] == 2'b00);
    wire       hit_flag = aligned & (idx == `CMPC_IDX_CORE_FLAG);
    wire       hit_data = aligned & (idx == `CMPC_IDX_PORT_DATA);
    wire       hit_ctrl = aligned & (idx == `CMPC_IDX_CONTROL);
    wire       hit_dir  = aligned & (idx == `CMPC_IDX_PIN_DIR);
    wire       hit_topt = aligned & (idx == `CMPC_IDX_TIMER_OPT);
    wire       mapped   = hit_flag | hit_data | hit_ctrl | hit_dir | hit_topt;
    wire       wr       = access & pwrite & mapped;
    wire       rd       = access & ~pwrite & mapped;

    // no wait states; unmapped or misaligned addresses answer an error
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    ////////////////////////////////////////////////////////////////////
    // comparator steering and result

    wire power_on = control_q[`CMPC_B_POWER] & released_q;
    wire drive_n  = control_q[`CMPC_B_DRIVE_N];
    wire pol_keep = control_q[`CMPC_B_POLARITY];
    // selects fall back to their reset meaning while powered down
    assign comparator_power      = power_on;
    assign negative_input_select = power_on ?
        control_q[`CMPC_B_NEG_SEL] : 1'b1;
    assign positive_input_select = power_on ?
        control_q[`CMPC_B_POS_SEL] : 1'b1;

    // a powered-down comparator reads as low before polarity
    wire raw_gated = raw_s & power_on;
    wire result    = pol_keep ? raw_gated : ~raw_gated;
    assign compare_result = result;

    ////////////////////////////////////////////////////////////////////
    // mode change window: any write that alters steering restarts it

    wire mode_change = wr & hit_ctrl &
        ((pwdata[5:1] != control_q[5:1]));

    cmpc_settle #(
        .CYCLES  (MODE_DELAY_CYC),
        .CW      (16)
    ) u_settle (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (mode_change),
        .busy    (result_unreliable)
    );

    ////////////////////////////////////////////////////////////////////
    // timer clock source

    wire tmr_clk_sel = timer_opt_q[`CMPC_B_TMR_CLK_SEL];
    // the source select has no say while the comparator is off
    wire tmr_src_pin = ~power_on | control_q[`CMPC_B_TMR_SRC];
    assign timer_tick_source = ~tmr_clk_sel ? instr_cycle :
        ((tmr_src_pin & drive_n) ? pin2_s : result);

    ////////////////////////////////////////////////////////////////////
    // pins: analog inputs released, result pin and timer clock override

    wire pin0_analog = power_on;
    wire pin1_analog = power_on &
        (control_q[`CMPC_B_NEG_SEL] | ~control_q[`CMPC_B_POS_SEL]);
    wire result_out  = power_on & ~drive_n;

    assign port_pin_zero_o  = port_data_q[0];
    assign port_pin_zero_oe = ~pin_dir_q[0] & ~pin0_analog;
    assign port_pin_one_o   = port_data_q[1];
    assign port_pin_one_oe  = ~pin_dir_q[1] & ~pin1_analog;
    // result drive beats the timer override, which beats direction
    assign port_pin_two_o   = result_out ? result : port_data_q[2];
    assign port_pin_two_oe  = result_out ? 1'b1 :
        (tmr_clk_sel ? 1'b0 : ~pin_dir_q[2]);

    ////////////////////////////////////////////////////////////////////
    // wake detection

    // the reference is taken on every read of the control register
    wire ctrl_read   = rd & hit_ctrl;
    wire wake_enable = power_on & ~control_q[`CMPC_B_WAKE_N];
    wire changed     = (result != ref_result_q);
    // hold off during settling so a mode change is no false wake
    wire wake_set    = wake_enable & armed_q & sleep_active &
                       changed & ~result_unreliable;
    wire flag_clear  = (wr & hit_flag & ~pwdata[`CMPC_B_CWAKE_FLAG]) |
                       warm_reset;

    always @* begin
        ref_result_d = ref_result_q;
        armed_d      = armed_q;
        if (ctrl_read) begin
            ref_result_d = result;
            armed_d      = 1'b1;
        end
        wake_flag_d = wake_flag_q;
        if (flag_clear) begin
            wake_flag_d = 1'b0;
        end
        if (wake_set) begin
            wake_flag_d = 1'b1;
        end
    end

    assign compare_wake_flag = wake_flag_q;

    ////////////////////////////////////////////////////////////////////
    // register writes

    always @* begin
        control_d   = control_q;
        pin_dir_d   = pin_dir_q;
        port_data_d = port_data_q;
        timer_opt_d = timer_opt_q;
        if (wr & hit_ctrl) begin
            // the result bit is status and ignores writes
            control_d[6:0] = pwdata[6:0];
        end
        if (wr & hit_dir) begin
            pin_dir_d = pwdata[3:0];
        end
        if (wr & hit_data) begin
            port_data_d = pwdata[3:0];
        end
        if (wr & hit_topt) begin
            timer_opt_d = pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux, registered at the access edge

    reg [31:0] rdata_d;
    always @* begin
        rdata_d = 32'h0000_0000;
        if (hit_flag) begin
            rdata_d[`CMPC_B_PWAKE_FLAG] = pin_change_wake_flag;
            rdata_d[`CMPC_B_CWAKE_FLAG] = wake_flag_q;
        end
        if (hit_ctrl) begin
            rdata_d[7:0] = {result, control_q[6:0]};
        end
        if (hit_dir) begin
            rdata_d[3:0] = pin_dir_q;
        end
        if (hit_data) begin
            rdata_d[3:0] = {pin2_s, 1'b0, pin1_s, pin0_s};
        end
        if (hit_topt) begin
            rdata_d[7:0] = timer_opt_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // flops

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_q          <= `CMPC_CTRL_RESET;
            pin_dir_q          <= `CMPC_PIN_DIR_RESET;
            port_data_q        <= `CMPC_PORT_DATA_RESET;
            timer_opt_q        <= `CMPC_TIMER_OPT_RESET;
            wake_flag_q        <= 1'b0;
            ref_result_q       <= 1'b0;
            armed_q            <= 1'b0;
            released_q         <= 1'b0;
            compare_wake_reset <= 1'b0;
            prdata             <= 32'h0000_0000;
        end else begin
            released_q <= 1'b1;
            // warm reset keeps control and steering untouched
            control_q  <= control_d;
            if (warm_reset) begin
                pin_dir_q   <= `CMPC_PIN_DIR_RESET;
                timer_opt_q <= `CMPC_TIMER_OPT_RESET;
            end else begin
                pin_dir_q   <= pin_dir_d;
                timer_opt_q <= timer_opt_d;
            end
            port_data_q        <= port_data_d;
            wake_flag_q        <= wake_flag_d;
            ref_result_q       <= ref_result_d;
            armed_q            <= armed_d;
            // one pulse marks the wake as its own reset cause
            compare_wake_reset <= wake_set & ~wake_flag_q;
            if (rd) begin
                prdata <= rdata_d;
            end
        end
    end

endmodule // cmpc_top
`default_nettype wire

// ### core/cmpc_defines.vh
// Purpose: constants for the comparator control block
// Assumes: APB byte address = register index * 4
// Notes:   included by cmpc_top only
// Behaviour
// - result is 1 when plus input higher
// - result readable, write-ignored, routed to timer
// - result pin driven only when drive selected
// - polarity bit may invert result everywhere
// - timer clock from cycle, result or pin
// - minus input from pin or internal reference
// - plus input from plus or minus pin
// - wake flag needs enable, read, sleep, change
// - control read latches reference result
// - wake flag cleared by software or reset
// - enabled comparator keeps running in sleep
// - power-on loads all ones except port data (0), comparator on
// - result unreliable during mode change delay
// - timer clock select overrides pin direction
// - compare wake is a distinct reset cause
`ifndef CMPC_DEFINES_VH
`define CMPC_DEFINES_VH

`define CMPC_IDX_CORE_FLAG   6'h03
`define CMPC_IDX_PORT_DATA   6'h06
`define CMPC_IDX_CONTROL     6'h07
`define CMPC_IDX_PIN_DIR     6'h08
`define CMPC_IDX_TIMER_OPT   6'h09

`define CMPC_CTRL_RESET      8'hff
`define CMPC_PIN_DIR_RESET   4'hf
`define CMPC_PORT_DATA_RESET 4'h0
`define CMPC_TIMER_OPT_RESET 8'hff

`define CMPC_B_RESULT        7
`define CMPC_B_DRIVE_N       6
`define CMPC_B_POLARITY      5
`define CMPC_B_TMR_SRC       4
`define CMPC_B_POWER         3
`define CMPC_B_NEG_SEL       2
`define CMPC_B_POS_SEL       1
`define CMPC_B_WAKE_N        0

`define CMPC_B_CWAKE_FLAG    6
`define CMPC_B_PWAKE_FLAG    7
`define CMPC_B_TMR_CLK_SEL   5

`define CMPC_CLK_PERIOD_NS   20
`define CMPC_MODE_DELAY_NS   10000
`define CMPC_MODE_DELAY_CYC  ((`CMPC_MODE_DELAY_NS + `CMPC_CLK_PERIOD_NS - 1) / `CMPC_CLK_PERIOD_NS)

`endif

// ### core/cmpc_sync.v
// Purpose: two-stage synchroniser, one per bit
// Assumes: inputs are asynchronous to pclk
// Notes:   first stage is read only by the second
`default_nettype none
module cmpc_sync #(
    parameter W = 1
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta_q;
            reg stable_q;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_q   <= 1'b0;
                    stable_q <= 1'b0;
                end else begin
                    meta_q   <= async_in[i];
                    stable_q <= meta_q;
                end
            end
            assign sync_out[i] = stable_q;
        end
    endgenerate
endmodule // cmpc_sync
`default_nettype wire

// ### core/cmpc_settle.v
// Purpose: down-counter marking the mode change settle window
// Assumes: start is a one-cycle pulse on pclk
// Notes:   a new start during the window restarts it
`default_nettype none
module cmpc_settle #(
    parameter CYCLES = 500,
    parameter CW     = 16
) (
    input  wire pclk,
    input  wire presetn,
    input  wire start,
    output wire busy
);
    localparam [CW-1:0] LOAD = CYCLES;
    reg [CW-1:0] count_q;
    reg [CW-1:0] count_d;

    always @* begin
        count_d = count_q;
        if (start) begin
            count_d = LOAD;
        end else if (count_q != {CW{1'b0}}) begin
            count_d = count_q - {{(CW-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= {CW{1'b0}};
        end else begin
            count_q <= count_d;
        end
    end

    assign busy = (count_q != {CW{1'b0}});
endmodule // cmpc_settle
`default_nettype wire

// ### sim/cmpc_top_props.sv
// Purpose: port-level assertions for cmpc_top
// Assumes: one pclk domain, presetn async active low
// Notes:   bound into every cmpc_top instance
`default_nettype none
module cmpc_top_props #(
    parameter int MODE_DELAY_CYC = 500
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic sleep_active,
    input wire logic warm_reset,
    input wire logic port_pin_zero_oe,
    input wire logic port_pin_one_oe,
    input wire logic comparator_power,
    input wire logic negative_input_select,
    input wire logic positive_input_select,
    input wire logic result_unreliable,
    input wire logic compare_wake_flag,
    input wire logic compare_wake_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] run_q;
    // length of the current unreliable stretch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            run_q <= 16'h0000;
        else if (result_unreliable)
            run_q <= run_q + 16'h0001;
        else
            run_q <= 16'h0000;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence pulse_s;
        compare_wake_reset ##1 !compare_wake_reset;
    endsequence
    wake_pulse_a:
    assert property ($rose(compare_wake_flag) |-> ##[0:2] pulse_s)
        else $error("wake reset pulse missing");
    pulse_once_a:
    assert property (compare_wake_reset |-> pulse_s)
        else $error("wake reset pulse too long");
    wake_sleep_a:
    assert property ($rose(compare_wake_flag) |-> $past(sleep_active))
        else $error("wake flag set while awake");
    warm_clear_a:
    assert property (warm_reset && !sleep_active |=> !compare_wake_flag)
        else $error("warm reset kept wake flag");
    settle_len_a:
    assert property ($fell(result_unreliable) |-> run_q >= MODE_DELAY_CYC)
        else $error("settle window too short");
    settle_cause_a:
    assert property ($rose(result_unreliable) |->
        $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
        else $error("settle window without a write");
    power_por_a:
    assert property (!$past(presetn) |-> !comparator_power)
        else $error("comparator powered right after reset");
    sel_off_a:
    assert property (!comparator_power |->
        negative_input_select && positive_input_select)
        else $error("selects active while off");
    pin_zero_a:
    assert property (comparator_power |-> !port_pin_zero_oe)
        else $error("plus pin driven while comparing");
    pin_one_a:
    assert property (comparator_power && negative_input_select
        |-> !port_pin_one_oe)
        else $error("minus pin driven while comparing");
endmodule // cmpc_top_props
bind cmpc_top cmpc_top_props #(.MODE_DELAY_CYC(MODE_DELAY_CYC)) props_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .sleep_active(sleep_active), .warm_reset(warm_reset),
    .port_pin_zero_oe(port_pin_zero_oe), .port_pin_one_oe(port_pin_one_oe),
    .comparator_power(comparator_power),
    .negative_input_select(negative_input_select),
    .positive_input_select(positive_input_select),
    .result_unreliable(result_unreliable),
    .compare_wake_flag(compare_wake_flag),
    .compare_wake_reset(compare_wake_reset));
`default_nettype wire

// ### sim/cmpc_analog_model.sv
// Purpose: behavioural analog comparator with input steering
// Assumes: levels are unsigned codes, equal levels give 0
// Notes:   powered-off output is 0, no settling delay modelled
`default_nettype none
module cmpc_analog_model #(
    parameter logic [7:0] REF_LEVEL = 8'h80
) (
    input  wire logic [7:0] pos_pin_level,
    input  wire logic [7:0] neg_pin_level,
    input  wire logic       comparator_power,
    input  wire logic       negative_input_select,
    input  wire logic       positive_input_select,
    output wire logic       comparator_raw
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [7:0] plus_lvl;
    wire logic [7:0] minus_lvl;
    assign plus_lvl = positive_input_select ? pos_pin_level : neg_pin_level;
    assign minus_lvl = negative_input_select ? neg_pin_level : REF_LEVEL;
    // runs regardless of sleep
    assign comparator_raw = comparator_power & (plus_lvl > minus_lvl);
endmodule // cmpc_analog_model
`default_nettype wire

// ### sim/cmpc_top_test.sv
// Purpose: self-checking bench for cmpc_top
// Assumes: zero-wait APB slave, settle window shortened to 5
// Notes:   random configs plus wake, warm reset and second POR
`default_nettype none
module cmpc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DLY = 5;
    logic pclk, presetn, psel, penable, pwrite, sleep_active, warm_reset;
    logic instr_cycle, pin0_i, pin1_i, pin2_i, err, tcs;
    logic [7:0] paddr, pos_lvl, neg_lvl, ctl;
    logic [31:0] pwdata, rd;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, raw, p0o, p0e, p1o, p1e, p2o, p2e;
    wire logic pwr, neg_sel, pos_sel, cres, unrel, tick, wflag, wrst;
    integer seed = 32'hac10;
    int mismatches = 0;
    int check_count = 0;
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    cmpc_top #(.MODE_DELAY_CYC(DLY)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .comparator_raw(raw), .sleep_active(sleep_active),
        .warm_reset(warm_reset), .pin_change_wake_flag(1'b0),
        .instr_cycle(instr_cycle), .port_pin_zero_i(pin0_i),
        .port_pin_one_i(pin1_i), .port_pin_two_i(pin2_i),
        .port_pin_zero_o(p0o), .port_pin_zero_oe(p0e), .port_pin_one_o(p1o),
        .port_pin_one_oe(p1e), .port_pin_two_o(p2o), .port_pin_two_oe(p2e),
        .comparator_power(pwr), .negative_input_select(neg_sel),
        .positive_input_select(pos_sel), .compare_result(cres),
        .result_unreliable(unrel), .timer_tick_source(tick),
        .compare_wake_flag(wflag), .compare_wake_reset(wrst));
    cmpc_analog_model model_u (.pos_pin_level(pos_lvl),
        .neg_pin_level(neg_lvl), .comparator_power(pwr),
        .negative_input_select(neg_sel), .positive_input_select(pos_sel),
        .comparator_raw(raw));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        if (mismatches == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1 rd = prdata;
    endtask
    // expected result: powered-off comparator reads as 0 before polarity
    function automatic logic exp_res(input logic [7:0] c);
        logic [7:0] plus, minus;
        logic r;
        plus = c[1] ? pos_lvl : neg_lvl;
        minus = c[2] ? neg_lvl : 8'h80;
        r = c[3] & (plus > minus);
        return c[5] ? r : ~r;
    endfunction
    // settle window plus two synchroniser stages and margin
    task automatic settle;
        repeat (DLY + 6) @(posedge pclk);
        #1;
    endtask
    always @(posedge pclk) instr_cycle <= 1'($random(seed));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, sleep_active, warm_reset} = 5'h00;
        {pin0_i, pin1_i, pin2_i} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pos_lvl = 8'h10;
        neg_lvl = 8'h20;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h1c, 0);
        check("ctl por", rd, 32'h0000_007f);
        apb(0, 8'h40, 0);
        check("unmapped err", 32'(err), 32'h0000_0001);
        for (int i = 0; i < 40; i++) begin
            ctl = 8'($random(seed));
            ctl[3] = (i % 8 != 0);
            tcs = 1'($random(seed));
            pos_lvl <= 8'($random(seed));
            neg_lvl <= 8'($random(seed));
            {pin0_i, pin1_i, pin2_i} <= 3'($random(seed));
            apb(1, 8'h24, {24'h0, 2'b11, tcs, 5'h1f});
            apb(1, 8'h1c, {24'h0, ctl});
            settle;
            check("result", 32'(cres), 32'(exp_res(ctl)));
            apb(0, 8'h1c, 0);
            check("ctl read", rd, {24'h0, exp_res(ctl), ctl[6:0]});
            if (!ctl[6] && ctl[3])
                check("pin2", {p2e, p2o}, {1'b1, exp_res(ctl)});
            else if (tcs)
                check("pin2 oe", 32'(p2e), 0);
            check("tick", 32'(tick), !tcs ? instr_cycle :
                (((ctl[4] | ~ctl[3]) & ctl[6]) ? pin2_i : exp_res(ctl)));
        end
        pos_lvl <= 8'h10;
        apb(1, 8'h20, 0);
        apb(1, 8'h1c, 32'h0000_006a);
        settle;
        apb(0, 8'h1c, 0);
        sleep_active <= 1'b1;
        pos_lvl <= 8'hf0;
        for (int k = 0; k < 20 && wflag !== 1'b1; k++) @(posedge pclk);
        #1 check("wake flag", 32'(wflag), 1);
        apb(0, 8'h0c, 0);
        check("core wake bit", 32'(rd[6]), 1);
        sleep_active <= 1'b0;
        apb(1, 8'h0c, 0);
        check("wake clear", 32'(wflag), 0);
        warm_reset <= 1'b1;
        @(posedge pclk);
        warm_reset <= 1'b0;
        apb(0, 8'h1c, 0);
        check("ctl warm", rd, 32'h0000_00ea);
        apb(0, 8'h20, 0);
        check("dir warm", rd, 32'h0000_000f);
        // levels that give a low result whatever the sync latency
        pos_lvl <= 8'h10;
        neg_lvl <= 8'h20;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h1c, 0);
        check("ctl por again", rd, 32'h0000_007f);
        tally_and_finish;
    end
    initial begin
        #(20 * 20000);
        mismatches++;
        tally_and_finish;
    end
endmodule // cmpc_top_test
`default_nettype wire
